// ### afe_powerup_bias_leadoff_setup.sv
// What this block does
// - bias electrode check by current source or pull-down, comparator judges.
// - with bias amplifier on, bias current source is off; comparator senses.
// - bias comparator threshold comes from lead-off control bits 7:5.
// - a config two or config three bit picks internal mid-supply; external bias reference needs both clear.
// - config three bit 2 clear turns the bias amplifier off; set powers it.
// - writing 02h to config four enables dc lead-off comparators.
// - writing FFh to sense selects enables lead-off on all channels.
// - lead-off status bits go out in the data stream.
// - writing 07h to bias selects uses channels one to three.
// - config three x11x1100 powers bias, internal ref; bit 4 measures.
// - channel input-select 0111 routes bias return pin to negative input.
// - channel input-select 0010 measures bias return versus bias reference.
// - config four bit 1 enables comparators, defaults disabled.
`timescale 1ns/1ps
module afe_powerup_bias_leadoff_setup
(
  input wire logic sys_clk, // master clock, 40 MHz
  input wire logic nrst, // host reset pulse, active low
  input wire logic register_write_cmd, // one-cycle register write strobe
  input wire logic [7:0] wr_addr, // register index
  input wire logic [7:0] wr_data, // register value
  input wire logic [7:0] comp_pos_raw, // positive-input comparators
  input wire logic [7:0] comp_neg_raw, // negative-input comparators
  input wire logic bias_comp_raw, // bias drive pin comparator
  output logic [2:0] comp_threshold, // comparator dac code
  output logic [1:0] leadoff_current_mag, // excitation current size
  output logic [1:0] leadoff_freq_sel, // excitation frequency
  output logic leadoff_comparator_enable, // comparators powered
  output logic [7:0] positive_leadoff_sense_sel, // p-side sense enables
  output logic [7:0] negative_leadoff_sense_sel, // n-side sense enables
  output logic [7:0] positive_bias_derive_sel, // p-side bias inputs
  output logic [7:0] negative_bias_derive_sel, // n-side bias inputs
  output logic bias_amp_power_down, // bias amplifier off
  output logic bias_ref_internal_sel, // internal mid-supply reference
  output logic bias_meas_enable, // bias measurement on
  output logic bias_current_enable, // bias lead-off current source
  output logic [7:0] route_bias_to_pos, // bias return to p-input
  output logic [7:0] route_bias_to_neg, // bias return to n-input
  output logic [7:0] measure_bias_chan, // channel reads bias vs ref
  output logic [7:0] leadoff_stat_pos, // p-side lead-off status
  output logic [7:0] leadoff_stat_neg, // n-side lead-off status
  output logic bias_leadoff_stat // bias electrode off
);
  import afe_setup_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // configuration storage

  logic [7:0] leadoff_control_reg;
  logic [7:0] config_reg_two;
  logic [7:0] config_reg_three;
  logic [7:0] config_reg_four;
  logic [7:0] chan_setting [NUM_CHAN];
  logic [7:0] comp_pos;
  logic [7:0] comp_neg;
  logic bias_comp;
  logic [7:0] next_stat_pos;
  logic [7:0] next_stat_neg;

  // writes land on the strobe edge, one register per process; an index
  // that matches none of them is dropped without any trace

  // lead-off threshold, excitation size and excitation frequency
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      leadoff_control_reg <= RST_REG;
    else if (register_write_cmd && wr_addr == ADDR_LEADOFF_CTRL)
      leadoff_control_reg <= wr_data;
  end

  // bias loop reference choice
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      config_reg_two <= RST_REG;
    else if (register_write_cmd && wr_addr == ADDR_CONFIG_TWO)
      config_reg_two <= wr_data;
  end

  // bias amplifier power, reference, measurement and lead-off sense
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      config_reg_three <= RST_CONFIG_THREE;
    else if (register_write_cmd && wr_addr == ADDR_CONFIG_THREE)
      config_reg_three <= wr_data;
  end

  // comparator power; comes up off so no stale status leaks out
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      config_reg_four <= RST_REG; // comparators off
    else if (register_write_cmd && wr_addr == ADDR_CONFIG_FOUR)
      config_reg_four <= wr_data;
  end

  // p-side lead-off sense enables
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      positive_leadoff_sense_sel <= RST_REG;
    else if (register_write_cmd && wr_addr == ADDR_LEADOFF_CONTROL_REG_SENSE_P)
      positive_leadoff_sense_sel <= wr_data;
  end

  // n-side lead-off sense enables
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      negative_leadoff_sense_sel <= RST_REG;
    else if (register_write_cmd && wr_addr == ADDR_LEADOFF_CONTROL_REG_SENSE_N)
      negative_leadoff_sense_sel <= wr_data;
  end

  // p-side inputs feeding the common-mode derivation
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      positive_bias_derive_sel <= RST_REG;
    else if (register_write_cmd && wr_addr == ADDR_BIAS_SEL_P)
      positive_bias_derive_sel <= wr_data;
  end

  // n-side inputs feeding the common-mode derivation
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      negative_bias_derive_sel <= RST_REG;
    else if (register_write_cmd && wr_addr == ADDR_BIAS_SEL_N)
      negative_bias_derive_sel <= wr_data;
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-channel setting registers and input routing

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHAN; ch++)
    begin : g_chan
      localparam logic [7:0] CH_ADDR = ADDR_CHAN_FIRST + 8'(ch);

      always_ff @(posedge sys_clk or negedge nrst)
      begin
        if (!nrst)
          chan_setting[ch] <= RST_REG;
        else if (register_write_cmd && wr_addr == CH_ADDR)
          chan_setting[ch] <= wr_data;
      end

      // routing is a decode of the low nibble only
      assign route_bias_to_pos[ch] = chan_setting[ch][3:0] == MUX_BIAS_TO_P;
      assign route_bias_to_neg[ch] =
        chan_setting[ch][3:0] == MUX_BIAS_TO_N;
      assign measure_bias_chan[ch] =
        chan_setting[ch][3:0] == MUX_BIAS_MEAS;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // decoded analog controls

  // one threshold field serves positive and negative inputs and the bias sense
  assign comp_threshold = leadoff_control_reg[THRESH_HI:THRESH_LO];
  assign leadoff_current_mag = leadoff_control_reg[ILEAD_HI:ILEAD_LO];
  assign leadoff_freq_sel = leadoff_control_reg[FLEAD_HI:FLEAD_LO];
  assign leadoff_comparator_enable =
    config_reg_four[CFG4_COMP_EN_BIT];
  assign bias_amp_power_down = !config_reg_three[CFG3_BIAS_ON_BIT];
  // either bit selects internal mid-supply, so both setup styles work
  assign bias_ref_internal_sel = config_reg_two[CFG2_REF_INT_BIT] ||
    config_reg_three[CFG3_REF_INT_BIT];
  assign bias_meas_enable = config_reg_three[CFG3_MEAS_BIT];
  // the source would fight a powered amplifier, so it is gated off
  assign bias_current_enable = config_reg_three[CFG3_BIAS_LEADOFF_CONTROL_REG_BIT] &&
    bias_amp_power_down;

  ////////////////////////////////////////////////////////////////////////////
  // comparator sampling and lead-off status

  afe_sync_bits #(.WIDTH(2 * NUM_CHAN + 1)) u_comp_sync
  (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .async_in({bias_comp_raw, comp_neg_raw, comp_pos_raw}),
    .sync_out({bias_comp, comp_neg, comp_pos})
  );

  // status only counts where comparators are on and sensing is selected
  always_comb
  begin
    next_stat_pos = '0;
    next_stat_neg = '0;
    if (leadoff_comparator_enable)
    begin
      next_stat_pos = comp_pos & positive_leadoff_sense_sel;
      next_stat_neg = comp_neg & negative_leadoff_sense_sel;
    end
  end

  // status words feed the output data stream
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      leadoff_stat_pos <= '0;
      leadoff_stat_neg <= '0;
    end
    else
    begin
      leadoff_stat_pos <= next_stat_pos;
      leadoff_stat_neg <= next_stat_neg;
    end
  end

  // bias check: comparator alone judges, source or pull-down excites it
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      bias_leadoff_stat <= 1'b0;
    else
      bias_leadoff_stat <= config_reg_three[CFG3_BIAS_LEADOFF_CONTROL_REG_BIT] &&
        bias_comp;
  end
endmodule

// ### afe_setup_pkg.sv
package afe_setup_pkg;
  // register indices on the write port
  localparam logic [7:0] ADDR_CONFIG_TWO = 8'h02;
  localparam logic [7:0] ADDR_CONFIG_THREE = 8'h03;
  localparam logic [7:0] ADDR_LEADOFF_CTRL = 8'h04;
  localparam logic [7:0] ADDR_CHAN_FIRST = 8'h05;
  localparam logic [7:0] ADDR_BIAS_SEL_P = 8'h0D;
  localparam logic [7:0] ADDR_BIAS_SEL_N = 8'h0E;
  localparam logic [7:0] ADDR_LEADOFF_CONTROL_REG_SENSE_P = 8'h0F;
  localparam logic [7:0] ADDR_LEADOFF_CONTROL_REG_SENSE_N = 8'h10;
  localparam logic [7:0] ADDR_CONFIG_FOUR = 8'h17;
  localparam int NUM_CHAN = 8;
  // reset values
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] RST_CONFIG_THREE = 8'h60;
  // host timing around the reset pulse, in master clock periods
  localparam int POR_WAIT_CYCLES = 65536;
  localparam int RST_LOW_CYCLES = 2;
  // field positions
  localparam int THRESH_HI = 7;
  localparam int THRESH_LO = 5;
  localparam int ILEAD_HI = 3;
  localparam int ILEAD_LO = 2;
  localparam int FLEAD_HI = 1;
  localparam int FLEAD_LO = 0;
  localparam int CFG2_REF_INT_BIT = 3;
  localparam int CFG3_MEAS_BIT = 4;
  localparam int CFG3_REF_INT_BIT = 3;
  localparam int CFG3_BIAS_ON_BIT = 2;
  localparam int CFG3_BIAS_LEADOFF_CONTROL_REG_BIT = 1;
  localparam int CFG4_COMP_EN_BIT = 1;
  // input-select codes of a channel setting register
  localparam logic [3:0] MUX_BIAS_MEAS = 4'h2;
  localparam logic [3:0] MUX_BIAS_TO_P = 4'h6;
  localparam logic [3:0] MUX_BIAS_TO_N = 4'h7;
  // synchroniser depth
  localparam int SYNC_STAGES = 2;
endpackage

// ### afe_sync_bits.sv
`timescale 1ns/1ps
module afe_sync_bits
#(
  parameter int WIDTH = 1
)
(
  input wire logic sys_clk, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic [WIDTH-1:0] async_in, // pin level
  output logic [WIDTH-1:0] sync_out // level in sys_clk domain
);
  import afe_setup_pkg::*;

  logic [WIDTH-1:0] stage_a;

  // two flops; the first is read only by the second
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      stage_a <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage_a <= async_in;
      sync_out <= stage_a;
    end
  end
endmodule

// ### afe_setup_properties.sv
`timescale 1ns/1ps
module afe_setup_properties
(
  input wire logic sys_clk, // clk
  input wire logic nrst, // rst
  input wire logic register_write_cmd, // strobe
  input wire logic [7:0] wr_addr, // index
  input wire logic [7:0] wr_data, // value
  input wire logic [2:0] comp_threshold, // dac
  input wire logic leadoff_comparator_enable, // comp on
  input wire logic bias_amp_power_down, // amp off
  input wire logic bias_meas_enable, // meas
  input wire logic bias_current_enable, // current
  input wire logic [7:0] leadoff_stat_pos // status
);
  import afe_setup_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // write strobes decoded per register
  wire logic w_leadoff_control_reg = register_write_cmd && wr_addr == ADDR_LEADOFF_CTRL;
  wire logic w_c3 = register_write_cmd && wr_addr == ADDR_CONFIG_THREE;
  wire logic w_c4 = register_write_cmd && wr_addr == ADDR_CONFIG_FOUR;
  ////////////////////////////////////////////////////////////////////////////
  // each write must land in the very next cycle
  comp_enable_a: assert property (
    w_c4 |=> leadoff_comparator_enable == $past(wr_data[1]))
    else $error("comp enable");
  thresh_field_a: assert property (
    w_leadoff_control_reg |=> comp_threshold == $past(wr_data[7:5]))
    else $error("threshold");
  bias_pd_a: assert property (
    w_c3 |=> bias_amp_power_down != $past(wr_data[2]))
    else $error("bias power");
  bias_meas_a: assert property (
    w_c3 |=> bias_meas_enable == $past(wr_data[4]))
    else $error("bias meas");
  current_off_a: assert property (
    !bias_amp_power_down |-> !bias_current_enable)
    else $error("current on");
  // status is gated after the sync pipe, so it is forced low one cycle after enable drops
  stat_gate_a: assert property (
    !leadoff_comparator_enable [*5] |-> leadoff_stat_pos == 8'h00)
    else $error("stat gated");
  thresh_hold_a: assert property (
    !register_write_cmd |=> $stable(comp_threshold))
    else $error("threshold moved");
  reset_val_a: assert property (
    $rose(nrst) |-> bias_amp_power_down && !leadoff_comparator_enable)
    else $error("reset value");
  cover property (w_c4 && wr_data == 8'h02);
  cover property (leadoff_stat_pos != 8'h00);
  cover property (!bias_amp_power_down);
endmodule
bind afe_powerup_bias_leadoff_setup afe_setup_properties chk (.*);

// ### afe_host_model.sv
`timescale 1ns/1ps
module afe_host_model
(
  input wire logic sys_clk, // clk
  input wire logic nrst, // rst
  output logic cmd = 1'b0, // strobe
  output logic [7:0] addr = 8'h00, // index
  output logic [7:0] data = 8'h00, // value
  output logic done // sequence over
);
  import afe_setup_pkg::*;
  // quick-start writes: lead-off, then bias drive and routing
  logic [15:0] seq [9] = '{{ADDR_LEADOFF_CTRL, 8'h00},
    {ADDR_CONFIG_FOUR, 8'h02}, {ADDR_LEADOFF_CONTROL_REG_SENSE_P, 8'hFF},
    {ADDR_LEADOFF_CONTROL_REG_SENSE_N, 8'hFF}, {ADDR_BIAS_SEL_P, 8'h07},
    // a lone device keeps its own bias amplifier powered
    {ADDR_BIAS_SEL_N, 8'h07}, {ADDR_CONFIG_THREE, 8'h7C},
    {8'h08, 8'h07}, {8'h09, 8'h02}};
  int idx = 0;
  // one write at a time, an idle cycle between, none during reset
  always @(negedge sys_clk or negedge nrst)
    if (!nrst)
    begin
      idx <= 0;
      cmd <= 1'b0;
    end
    else if (idx < 9 && !cmd)
    begin
      cmd <= 1'b1;
      {addr, data} <= seq[idx];
      idx <= idx + 1;
    end
    else
    begin
      cmd <= 1'b0;
      data <= ~data; // released bus does not keep the old byte
    end
  assign done = idx == 9 && !cmd;
endmodule

// ### afe_powerup_bias_leadoff_setup_tb.sv
`timescale 1ns/1ps
module afe_powerup_bias_leadoff_setup_tb;
  import afe_setup_pkg::*;
  logic sys_clk = 1'b0, nrst = 1'b0, sel = 1'b0, b_cmd = 1'b0;
  logic h_cmd, h_done, register_write_cmd, bias_comp_raw = 1'b0;
  logic [7:0] h_addr, h_data, wr_addr, wr_data, sp, sn, d;
  logic [7:0] b_addr = 8'h00, b_data = 8'h00;
  logic [7:0] comp_pos_raw = 8'h00, comp_neg_raw = 8'h00;
  logic [2:0] comp_threshold;
  logic [1:0] leadoff_current_mag, leadoff_freq_sel;
  logic leadoff_comparator_enable, bias_amp_power_down, bias_ref_internal_sel;
  logic bias_meas_enable, bias_current_enable, bias_leadoff_stat;
  logic [7:0] positive_leadoff_sense_sel, negative_leadoff_sense_sel;
  logic [7:0] positive_bias_derive_sel, negative_bias_derive_sel;
  logic [7:0] route_bias_to_pos, route_bias_to_neg, measure_bias_chan;
  logic [7:0] leadoff_stat_pos, leadoff_stat_neg;
  logic [3:0] nib [8];
  int errors = 0, num_checks = 0;
  // host model first, then the bench owns the write port
  assign register_write_cmd = sel ? b_cmd : h_cmd;
  assign wr_addr = sel ? b_addr : h_addr;
  assign wr_data = sel ? b_data : h_data;
  afe_host_model host (.sys_clk(sys_clk), .nrst(nrst), .cmd(h_cmd),
    .addr(h_addr), .data(h_data), .done(h_done));
  afe_powerup_bias_leadoff_setup DUT (.*);
  initial
    forever #12.5 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [7:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge sys_clk);
    {b_cmd, b_addr, b_data} = {1'b1, a, v};
    @(negedge sys_clk);
    b_cmd = 1'b0;
  endtask
  // expected bit mask of channels whose input-select equals code
  function automatic logic [7:0] dec(input logic [3:0] code);
    for (int c = 0; c < NUM_CHAN; c++)
      dec[c] = nib[c] == code;
  endfunction
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // main sequence; a reset at the end checks the bias power and comparator reset values
  initial
  begin
    void'($urandom(86487));
    repeat (5) @(negedge sys_clk);
    nrst = 1'b1;
    for (int i = 0; i < 100 && h_done !== 1'b1; i++) @(negedge sys_clk);
    chk("host_done", h_done, 8'h01);
    chk("threshold", comp_threshold, 8'h00);
    chk("ilead0", leadoff_current_mag, 8'h00);
    chk("flead0", leadoff_freq_sel, 8'h00);
    chk("comp_en", leadoff_comparator_enable, 8'h01);
    chk("sense_p", positive_leadoff_sense_sel, 8'hFF);
    chk("sense_n", negative_leadoff_sense_sel, 8'hFF);
    chk("derive_p", positive_bias_derive_sel, 8'h07);
    chk("derive_n", negative_bias_derive_sel, 8'h07);
    chk("bias", {bias_amp_power_down, bias_ref_internal_sel,
      bias_meas_enable}, 8'h03);
    chk("cur", bias_current_enable, 8'h00);
    chk("to_neg", route_bias_to_neg, 8'h08);
    chk("meas", measure_bias_chan, 8'h10);
    sel = 1'b1;
    for (int i = 0; i < 24; i++)
    begin
      if (i == 16) wr(ADDR_CONFIG_FOUR, 8'h00);
      d = 8'($urandom);
      sp = (i < 4) ? 8'hFF : 8'($urandom);
      sn = 8'($urandom);
      wr(ADDR_LEADOFF_CTRL, d);
      wr(8'h11, ~d); // unmapped index is ignored
      chk("thr", comp_threshold, {5'h00, d[7:5]});
      chk("ilead", leadoff_current_mag, {6'h00, d[3:2]});
      chk("flead", leadoff_freq_sel, {6'h00, d[1:0]});
      wr(ADDR_LEADOFF_CONTROL_REG_SENSE_P, sp);
      wr(ADDR_LEADOFF_CONTROL_REG_SENSE_N, sn);
      {comp_pos_raw, comp_neg_raw} = 16'($urandom);
      repeat (4) @(negedge sys_clk);
      chk("stat_p", leadoff_stat_pos,
        i < 16 ? comp_pos_raw & sp : 8'h00);
      chk("stat_n", leadoff_stat_neg,
        i < 16 ? comp_neg_raw & sn : 8'h00);
    end
    wr(ADDR_CONFIG_THREE, 8'h62);
    bias_comp_raw = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk("cur_on", {bias_amp_power_down,
      bias_current_enable}, 8'h03);
    chk("bias_off", bias_leadoff_stat, 8'h01);
    chk("ref_ext", bias_ref_internal_sel, 8'h00);
    wr(ADDR_CONFIG_TWO, 8'h08);
    chk("ref_int", bias_ref_internal_sel, 8'h01);
    wr(ADDR_CONFIG_THREE, 8'h66);
    chk("cur_off", bias_current_enable, 8'h00);
    chk("bias_sense", bias_leadoff_stat, 8'h01);
    for (int c = 0; c < NUM_CHAN; c++)
    begin
      nib[c] = c == 0 ? 4'h2 : c == 1 ? 4'h6 : c == 2 ? 4'h7 : 4'($urandom);
      wr(ADDR_CHAN_FIRST + 8'(c), {4'($urandom), nib[c]});
    end
    chk("to_pos", route_bias_to_pos, dec(MUX_BIAS_TO_P));
    chk("to_n", route_bias_to_neg, dec(MUX_BIAS_TO_N));
    chk("meas_ch", measure_bias_chan, dec(MUX_BIAS_MEAS));
    // turn the comparators on so the reset visibly clears them
    wr(ADDR_CONFIG_FOUR, 8'h02);
    // no reset pulse sooner than the power-on wait after clock start
    repeat (POR_WAIT_CYCLES) @(negedge sys_clk);
    nrst = 1'b0;
    repeat (RST_LOW_CYCLES) @(negedge sys_clk);
    chk("rst", {bias_amp_power_down,
      leadoff_comparator_enable}, 8'h02);
    nrst = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk("rst_rel", {bias_amp_power_down,
      leadoff_comparator_enable}, 8'h02);
    final_report();
  end
  // watchdog past the expected run of about 66 thousand cycles
  initial
  begin
    #2000000;
    errors++;
    final_report();
  end
endmodule
